/* File: hw/pbacs_pkg.sv */
package pbacs_pkg;

  // bus geometry
  localparam int          ADDR_W            = 12;
  localparam int          DATA_W            = 32;
  localparam int          STRB_W            = 4;

  // register byte offsets
  localparam logic [11:0] OFF_PB_HDR        = 12'h20C;
  localparam logic [11:0] OFF_SEL           = 12'h210;
  localparam logic [11:0] OFF_DATA          = 12'h214;
  localparam logic [11:0] OFF_ALLOC         = 12'h218;
  localparam logic [11:0] OFF_ACS_HDR       = 12'h220;
  localparam logic [11:0] OFF_ACS_CAP       = 12'h224;
  localparam logic [11:0] OFF_EGRESS        = 12'h228;

  // extended capability headers
  localparam logic [15:0] PB_CAP_ID         = 16'h0004;
  localparam logic [15:0] ACS_CAP_ID        = 16'h000D;
  localparam logic [3:0]  CAP_VER           = 4'h1;
  localparam logic [11:0] NEXT_UP           = 12'h230;
  localparam logic [11:0] NEXT_DS           = 12'h220;
  localparam logic [11:0] NEXT_END          = 12'h000;

  // budget entry select
  localparam logic [7:0]  SEL_RESET         = 8'h00;
  localparam logic [7:0]  SEL_D0_MAX        = 8'h00;
  localparam logic [7:0]  SEL_D0_SUST       = 8'h01;

  // budget entry fields
  localparam int          BASE_LSB          = 0;
  localparam int          SCALE_LSB         = 8;
  localparam int          SUB_LSB           = 10;
  localparam int          PMST_LSB          = 13;
  localparam int          TYPE_LSB          = 15;
  localparam int          RAIL_LSB          = 18;
  localparam logic [7:0]  BASE_POWER_RESET  = 8'h04;
  localparam logic [1:0]  SCALE_RESET       = 2'h0;
  localparam logic [2:0]  SUB_RESET         = 3'h0;
  localparam logic [1:0]  PMST_D0           = 2'h0;
  localparam logic [2:0]  TYPE_MAX          = 3'h7;
  localparam logic [2:0]  TYPE_SUST         = 3'h1;
  localparam logic [2:0]  RAIL_RESET        = 3'h2;
  localparam logic        SYS_ALLOC_RESET   = 1'b0;

  // access control fields
  localparam int          ACS_FEAT_W        = 7;
  localparam int          ACS_ENA_LSB       = 16;
  localparam int          EGRESS_W          = 8;
  localparam logic [6:0]  ACS_CAP_BITS      = 7'h7F;
  localparam logic [7:0]  EGRESS_SIZE       = 8'h08;
  localparam logic [6:0]  ACS_ENA_RESET     = 7'h00;
  localparam logic [7:0]  EGRESS_RESET      = 8'h00;

  // bus responses
  localparam logic [1:0]  RESP_OKAY         = 2'h0;
  localparam logic [1:0]  RESP_SLVERR       = 2'h2;

  typedef enum logic [1:0] {
    PBACS_WR_COLLECT = 2'b01,
    PBACS_WR_RESP    = 2'b10
  } pbacs_wr_state_e;

  typedef enum logic [1:0] {
    PBACS_RD_IDLE = 2'b01,
    PBACS_RD_RESP = 2'b10
  } pbacs_rd_state_e;

endpackage

/* File: hw/pbacs_budget_entry.sv */
`timescale 1ns/10ps
module pbacs_budget_entry
  import pbacs_pkg::*;
(
  // selection and base power
  input  wire logic [7:0]  sel,
  input  wire logic [7:0]  base_power,
  // entry
  output logic      [31:0] entry
);

  always_comb begin
    entry = 32'h0000_0000;
    case (sel)
      SEL_D0_MAX: begin
        entry = {11'h000, RAIL_RESET, TYPE_MAX, PMST_D0, SUB_RESET, SCALE_RESET, base_power};
      end
      SEL_D0_SUST: begin
        entry = {11'h000, RAIL_RESET, TYPE_SUST, PMST_D0, SUB_RESET, SCALE_RESET, base_power};
      end
      default: begin
        entry = 32'h0000_0000;
      end
    endcase
  end

endmodule

/* File: hw/pbacs_axil_slave.sv */
`timescale 1ns/10ps
module pbacs_axil_slave
  import pbacs_pkg::*;
(
  // clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // write address
  input  wire logic [ADDR_W-1:0] s_axil_awaddr,
  input  wire logic              s_axil_awvalid,
  output logic                   s_axil_awready,
  // write data
  input  wire logic [DATA_W-1:0] s_axil_wdata,
  input  wire logic [STRB_W-1:0] s_axil_wstrb,
  input  wire logic              s_axil_wvalid,
  output logic                   s_axil_wready,
  // write response
  output logic      [1:0]        s_axil_bresp,
  output logic                   s_axil_bvalid,
  input  wire logic              s_axil_bready,
  // read address
  input  wire logic [ADDR_W-1:0] s_axil_araddr,
  input  wire logic              s_axil_arvalid,
  output logic                   s_axil_arready,
  // read data
  output logic      [DATA_W-1:0] s_axil_rdata,
  output logic      [1:0]        s_axil_rresp,
  output logic                   s_axil_rvalid,
  input  wire logic              s_axil_rready,
  // register side
  output logic                   wr_en,
  output logic      [ADDR_W-1:0] wr_addr,
  output logic      [DATA_W-1:0] wr_data,
  output logic      [STRB_W-1:0] wr_strb,
  input  wire logic              wr_err,
  output logic                   rd_en,
  output logic      [ADDR_W-1:0] rd_addr,
  input  wire logic [DATA_W-1:0] rd_data,
  input  wire logic              rd_err
);

  pbacs_wr_state_e   wr_state_reg;
  pbacs_rd_state_e   rd_state_reg;
  logic              aw_held_reg;
  logic              w_held_reg;
  logic [ADDR_W-1:0] awaddr_reg;
  logic [DATA_W-1:0] wdata_reg;
  logic [STRB_W-1:0] wstrb_reg;
  logic [1:0]        bresp_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic [1:0]        rresp_reg;

  assign s_axil_awready = (wr_state_reg == PBACS_WR_COLLECT) && !aw_held_reg;
  assign s_axil_wready  = (wr_state_reg == PBACS_WR_COLLECT) && !w_held_reg;
  assign s_axil_bvalid  = (wr_state_reg == PBACS_WR_RESP);
  assign s_axil_bresp   = bresp_reg;
  assign wr_en          = (wr_state_reg == PBACS_WR_COLLECT) && aw_held_reg && w_held_reg;
  assign wr_addr        = awaddr_reg;
  assign wr_data        = wdata_reg;
  assign wr_strb        = wstrb_reg;

  assign s_axil_arready = (rd_state_reg == PBACS_RD_IDLE);
  assign s_axil_rvalid  = (rd_state_reg == PBACS_RD_RESP);
  assign s_axil_rdata   = rdata_reg;
  assign s_axil_rresp   = rresp_reg;
  assign rd_en          = s_axil_arvalid && s_axil_arready;
  assign rd_addr        = s_axil_araddr;

  // write channel collection and response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state_reg <= PBACS_WR_COLLECT;
      aw_held_reg  <= 1'b0;
      w_held_reg   <= 1'b0;
      awaddr_reg   <= '0;
      wdata_reg    <= '0;
      wstrb_reg    <= '0;
      bresp_reg    <= RESP_OKAY;
    end else begin
      case (wr_state_reg)
        PBACS_WR_COLLECT: begin
          if (s_axil_awvalid && s_axil_awready) begin
            aw_held_reg <= 1'b1;
            awaddr_reg  <= s_axil_awaddr;
          end
          if (s_axil_wvalid && s_axil_wready) begin
            w_held_reg <= 1'b1;
            wdata_reg  <= s_axil_wdata;
            wstrb_reg  <= s_axil_wstrb;
          end
          if (wr_en) begin
            aw_held_reg  <= 1'b0;
            w_held_reg   <= 1'b0;
            bresp_reg    <= wr_err ? RESP_SLVERR : RESP_OKAY;
            wr_state_reg <= PBACS_WR_RESP;
          end
        end
        PBACS_WR_RESP: begin
          if (s_axil_bready) begin
            wr_state_reg <= PBACS_WR_COLLECT;
          end
        end
        default: begin
          wr_state_reg <= PBACS_WR_COLLECT;
        end
      endcase
    end
  end

  // read capture and response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_state_reg <= PBACS_RD_IDLE;
      rdata_reg    <= '0;
      rresp_reg    <= RESP_OKAY;
    end else begin
      case (rd_state_reg)
        PBACS_RD_IDLE: begin
          if (rd_en) begin
            rdata_reg    <= rd_data;
            rresp_reg    <= rd_err ? RESP_SLVERR : RESP_OKAY;
            rd_state_reg <= PBACS_RD_RESP;
          end
        end
        PBACS_RD_RESP: begin
          if (s_axil_rready) begin
            rd_state_reg <= PBACS_RD_IDLE;
          end
        end
        default: begin
          rd_state_reg <= PBACS_RD_IDLE;
        end
      endcase
    end
  end

endmodule

/* File: hw/pbacs_regs.sv */
`timescale 1ns/10ps
module pbacs_regs
  import pbacs_pkg::*;
(
  // clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // port role, sampled during reset
  input  wire logic              port_is_downstream,
  // external default load
  input  wire logic              eeprom_load,
  input  wire logic [7:0]        eeprom_base_power,
  input  wire logic              eeprom_sys_alloc,
  // write address
  input  wire logic [ADDR_W-1:0] s_axil_awaddr,
  input  wire logic              s_axil_awvalid,
  output logic                   s_axil_awready,
  // write data
  input  wire logic [DATA_W-1:0] s_axil_wdata,
  input  wire logic [STRB_W-1:0] s_axil_wstrb,
  input  wire logic              s_axil_wvalid,
  output logic                   s_axil_wready,
  // write response
  output logic      [1:0]        s_axil_bresp,
  output logic                   s_axil_bvalid,
  input  wire logic              s_axil_bready,
  // read address
  input  wire logic [ADDR_W-1:0] s_axil_araddr,
  input  wire logic              s_axil_arvalid,
  output logic                   s_axil_arready,
  // read data
  output logic      [DATA_W-1:0] s_axil_rdata,
  output logic      [1:0]        s_axil_rresp,
  output logic                   s_axil_rvalid,
  input  wire logic              s_axil_rready,
  // controls to the port logic
  output logic      [6:0]        acs_enable,
  output logic      [7:0]        egress_block
);

  logic              wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  logic [STRB_W-1:0] wr_strb;
  logic              wr_err;
  logic              rd_en;
  logic [ADDR_W-1:0] rd_addr;
  logic [DATA_W-1:0] rd_data;
  logic              rd_err;
  logic [DATA_W-1:0] entry;

  logic              port_ds_reg;
  logic [7:0]        sel_reg;
  logic [7:0]        base_power_reg;
  logic              sys_alloc_reg;
  logic [6:0]        acs_ena_reg;
  logic [7:0]        egress_reg;

  logic [DATA_W-1:0] pb_hdr;
  logic [DATA_W-1:0] acs_hdr;
  logic [DATA_W-1:0] acs_cap;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
    hit = (a[ADDR_W-1:2] == off[ADDR_W-1:2]);
  endfunction

  pbacs_axil_slave u_bus (
    .aclk           (aclk),
    .aresetn        (aresetn),
    .s_axil_awaddr  (s_axil_awaddr),
    .s_axil_awvalid (s_axil_awvalid),
    .s_axil_awready (s_axil_awready),
    .s_axil_wdata   (s_axil_wdata),
    .s_axil_wstrb   (s_axil_wstrb),
    .s_axil_wvalid  (s_axil_wvalid),
    .s_axil_wready  (s_axil_wready),
    .s_axil_bresp   (s_axil_bresp),
    .s_axil_bvalid  (s_axil_bvalid),
    .s_axil_bready  (s_axil_bready),
    .s_axil_araddr  (s_axil_araddr),
    .s_axil_arvalid (s_axil_arvalid),
    .s_axil_arready (s_axil_arready),
    .s_axil_rdata   (s_axil_rdata),
    .s_axil_rresp   (s_axil_rresp),
    .s_axil_rvalid  (s_axil_rvalid),
    .s_axil_rready  (s_axil_rready),
    .wr_en          (wr_en),
    .wr_addr        (wr_addr),
    .wr_data        (wr_data),
    .wr_strb        (wr_strb),
    .wr_err         (wr_err),
    .rd_en          (rd_en),
    .rd_addr        (rd_addr),
    .rd_data        (rd_data),
    .rd_err         (rd_err)
  );

  pbacs_budget_entry u_entry (
    .sel        (sel_reg),
    .base_power (base_power_reg),
    .entry      (entry)
  );

  assign pb_hdr  = {(port_ds_reg ? NEXT_DS : NEXT_UP), CAP_VER, PB_CAP_ID};
  assign acs_hdr = {NEXT_END, CAP_VER, ACS_CAP_ID};
  assign acs_cap = {9'h000, acs_ena_reg, EGRESS_SIZE, 1'b0, ACS_CAP_BITS};

  assign acs_enable   = acs_ena_reg;
  assign egress_block = egress_reg;

  // port role caught while reset held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_ds_reg <= port_is_downstream;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sel_reg <= SEL_RESET;
    end else if (wr_en && hit(wr_addr, OFF_SEL) && wr_strb[0]) begin
      sel_reg <= wr_data[7:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      base_power_reg <= BASE_POWER_RESET;
      sys_alloc_reg  <= SYS_ALLOC_RESET;
    end else if (eeprom_load) begin
      base_power_reg <= eeprom_base_power;
      sys_alloc_reg  <= eeprom_sys_alloc;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acs_ena_reg <= ACS_ENA_RESET;
    end else if (wr_en && port_ds_reg && hit(wr_addr, OFF_ACS_CAP) && wr_strb[2]) begin
      acs_ena_reg <= wr_data[ACS_ENA_LSB +: ACS_FEAT_W];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      egress_reg <= EGRESS_RESET;
    end else if (wr_en && port_ds_reg && hit(wr_addr, OFF_EGRESS) && wr_strb[0]) begin
      egress_reg <= wr_data[EGRESS_W-1:0];
    end
  end

  always_comb begin
    wr_err = 1'b1;
    if (hit(wr_addr, OFF_PB_HDR) || hit(wr_addr, OFF_SEL) ||
        hit(wr_addr, OFF_DATA) || hit(wr_addr, OFF_ALLOC)) begin
      wr_err = 1'b0;
    end else if (port_ds_reg && (hit(wr_addr, OFF_ACS_HDR) ||
                 hit(wr_addr, OFF_ACS_CAP) || hit(wr_addr, OFF_EGRESS))) begin
      wr_err = 1'b0;
    end
  end

  always_comb begin
    rd_data = 32'h0000_0000;
    rd_err  = 1'b0;
    if (hit(rd_addr, OFF_PB_HDR)) begin
      rd_data = pb_hdr;
    end else if (hit(rd_addr, OFF_SEL)) begin
      rd_data = {24'h000000, sel_reg};
    end else if (hit(rd_addr, OFF_DATA)) begin
      rd_data = entry;
    end else if (hit(rd_addr, OFF_ALLOC)) begin
      rd_data = {31'h0000_0000, sys_alloc_reg};
    end else if (port_ds_reg && hit(rd_addr, OFF_ACS_HDR)) begin
      rd_data = acs_hdr;
    end else if (port_ds_reg && hit(rd_addr, OFF_ACS_CAP)) begin
      rd_data = acs_cap;
    end else if (port_ds_reg && hit(rd_addr, OFF_EGRESS)) begin
      rd_data = {24'h000000, egress_reg};
    end else begin
      rd_err = 1'b1;
    end
  end

  AST_PB_HDR: assert property (
    @(posedge aclk) disable iff (!aresetn)
    rd_en && hit(rd_addr, OFF_PB_HDR) |=>
      s_axil_rvalid && (s_axil_rdata[19:0] == 20'h1_0004) && (s_axil_rresp == RESP_OKAY))
    else $error("budget header id or version wrong");

  AST_PB_NEXT: assert property (
    @(posedge aclk) disable iff (!aresetn)
    rd_en && hit(rd_addr, OFF_PB_HDR) |=>
      s_axil_rdata[31:20] == (port_ds_reg ? 12'h220 : 12'h230))
    else $error("budget next pointer wrong");

  AST_SEL_RESET: assert property (
    @(posedge aclk)
    !aresetn |=> (sel_reg == 8'h00) && (acs_enable == 7'h00) && (egress_block == 8'h00))
    else $error("control registers not cleared by reset");

  AST_DATA_MAX: assert property (
    @(posedge aclk) disable iff (!aresetn)
    rd_en && hit(rd_addr, OFF_DATA) && (sel_reg == 8'h00) |=>
      (s_axil_rdata[31:8] == 24'h00_0B80) && (s_axil_rdata[7:0] == $past(base_power_reg)))
    else $error("D0 maximum entry fields wrong");

  AST_DATA_SUST: assert property (
    @(posedge aclk) disable iff (!aresetn)
    rd_en && hit(rd_addr, OFF_DATA) && (sel_reg == 8'h01) |=>
      (s_axil_rdata[17:15] == TYPE_SUST) && (s_axil_rdata[20:18] == 3'b010))
    else $error("D0 sustained entry fields wrong");

  AST_DATA_UNSUP: assert property (
    @(posedge aclk) disable iff (!aresetn)
    rd_en && hit(rd_addr, OFF_DATA) && (sel_reg > 8'h01) |=> s_axil_rdata == 32'h0000_0000)
    else $error("unsupported entry not zero");

  AST_BASE_LOAD: assert property (
    @(posedge aclk) disable iff (!aresetn)
    eeprom_load |=> (base_power_reg == $past(eeprom_base_power)) &&
      (sys_alloc_reg == $past(eeprom_sys_alloc)))
    else $error("external load not applied");

  AST_BASE_RESET: assert property (
    @(posedge aclk)
    !aresetn |=> (base_power_reg == 8'h04) && (sys_alloc_reg == 1'b0))
    else $error("budget defaults wrong after reset");

  AST_ALLOC_READ: assert property (
    @(posedge aclk) disable iff (!aresetn)
    rd_en && hit(rd_addr, OFF_ALLOC) |=> s_axil_rdata == {31'h0000_0000, $past(sys_alloc_reg)})
    else $error("allocated flag read wrong");

  AST_ACS_HDR: assert property (
    @(posedge aclk) disable iff (!aresetn)
    rd_en && port_ds_reg && hit(rd_addr, OFF_ACS_HDR) |=> s_axil_rdata == 32'h0001_000D)
    else $error("access control header wrong");

  AST_ACS_UPSTREAM: assert property (
    @(posedge aclk) disable iff (!aresetn)
    rd_en && !port_ds_reg && (hit(rd_addr, OFF_ACS_HDR) || hit(rd_addr, OFF_ACS_CAP) ||
      hit(rd_addr, OFF_EGRESS)) |=> s_axil_rresp == RESP_SLVERR)
    else $error("access control visible on upstream port");

  AST_ACS_CAP: assert property (
    @(posedge aclk) disable iff (!aresetn)
    rd_en && port_ds_reg && hit(rd_addr, OFF_ACS_CAP) |=>
      (s_axil_rdata[15:0] == 16'h087F) && (s_axil_rdata[31:23] == 9'h000))
    else $error("access control capability bits wrong");

  AST_ENA_WRITE: assert property (
    @(posedge aclk) disable iff (!aresetn)
    wr_en && port_ds_reg && hit(wr_addr, OFF_ACS_CAP) && wr_strb[2] |=>
      (acs_enable == $past(wr_data[22:16])) && s_axil_bvalid)
    else $error("enable bits not written");

  AST_ENA_STRB: assert property (
    @(posedge aclk) disable iff (!aresetn)
    wr_en && hit(wr_addr, OFF_ACS_CAP) && !wr_strb[2] |=> $stable(acs_enable))
    else $error("enable bits written without their strobe");

  AST_ACS_WR_UPSTREAM: assert property (
    @(posedge aclk) disable iff (!aresetn)
    wr_en && !port_ds_reg && (hit(wr_addr, OFF_ACS_CAP) || hit(wr_addr, OFF_EGRESS)) |=>
      $stable(acs_enable) && $stable(egress_block) && (s_axil_bresp == RESP_SLVERR))
    else $error("access control written on upstream port");

  AST_SEL_WRITE: assert property (
    @(posedge aclk) disable iff (!aresetn)
    wr_en && hit(wr_addr, OFF_SEL) && wr_strb[0] |=>
      sel_reg == $past(wr_data[7:0]))
    else $error("select index not written");

  AST_DATA_LOW: assert property (
    @(posedge aclk) disable iff (!aresetn)
    rd_en && hit(rd_addr, OFF_DATA) && (sel_reg == 8'h01) |=>
      (s_axil_rdata[14:8] == 7'h00) && (s_axil_rdata[7:0] == $past(base_power_reg)))
    else $error("D0 sustained scale, state or base wrong");

  AST_DATA_RSVD: assert property (
    @(posedge aclk) disable iff (!aresetn)
    rd_en && hit(rd_addr, OFF_DATA) |=> s_axil_rdata[31:21] == 11'h000)
    else $error("budget data reserved bits not zero");

  AST_EGRESS_READ: assert property (
    @(posedge aclk) disable iff (!aresetn)
    rd_en && port_ds_reg && hit(rd_addr, OFF_EGRESS) |=>
      s_axil_rdata == {24'h000000, $past(egress_block)})
    else $error("egress vector read wrong");

  AST_RO_WRITE_OKAY: assert property (
    @(posedge aclk) disable iff (!aresetn)
    wr_en && (hit(wr_addr, OFF_PB_HDR) || hit(wr_addr, OFF_DATA) ||
      hit(wr_addr, OFF_ALLOC)) |=>
      s_axil_bvalid && (s_axil_bresp == RESP_OKAY))
    else $error("read-only write not answered okay");

  AST_EGRESS_WRITE: assert property (
    @(posedge aclk) disable iff (!aresetn)
    wr_en && port_ds_reg && hit(wr_addr, OFF_EGRESS) && wr_strb[0] |=>
      egress_block == $past(wr_data[7:0]))
    else $error("egress vector not written");

  AST_RO_IGNORE: assert property (
    @(posedge aclk) disable iff (!aresetn)
    wr_en && !eeprom_load && (hit(wr_addr, OFF_DATA) || hit(wr_addr, OFF_ALLOC)) |=>
      $stable(base_power_reg) && $stable(sys_alloc_reg) && $stable(sel_reg))
    else $error("read-only register changed by write");

  AST_SEL_RSVD: assert property (
    @(posedge aclk) disable iff (!aresetn)
    rd_en && hit(rd_addr, OFF_SEL) |=> s_axil_rdata[31:8] == 24'h000000)
    else $error("select reserved bits not zero");

endmodule

/* File: test/tb_top.sv */
`timescale 1ns/10ps
module tb_top
  import pbacs_pkg::*;
;
  // clock, reset and straps
  logic        aclk    = 1'h0;
  logic        aresetn = 1'h0;
  logic        ds      = 1'h1;
  logic        ld      = 1'h0;
  logic        sa      = 1'h0;
  logic [7:0]  bp      = 8'h00;
  // bus master side
  logic [11:0] awaddr  = 12'h000;
  logic [11:0] araddr  = 12'h000;
  logic [31:0] wdata   = 32'h0;
  logic [3:0]  wstrb   = 4'h0;
  logic        awvalid = 1'h0;
  logic        wvalid  = 1'h0;
  logic        bready  = 1'h0;
  logic        arvalid = 1'h0;
  logic        rready  = 1'h0;
  // design outputs
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [6:0]  acs_en;
  logic [7:0]  egr;
  // bookkeeping
  logic [33:0] rq [$];
  logic [1:0]  bq [$];
  logic [33:0] e;
  logic [7:0]  s;
  logic [31:0] rnd     = 32'hE55FC386;
  int          failures = 0;
  int          compares = 0;
  int          cyc      = 0;
  int          i;
  logic [7:0]  st [4]  = '{8'h00, 8'h01, 8'h02, 8'hFF};
  logic [11:0] ro [4]  = '{OFF_PB_HDR, OFF_DATA, OFF_ALLOC, OFF_ACS_HDR};
  logic [31:0] re [4]  = '{32'h2201_0004, 32'h000B_8004, 32'h0, 32'h0001_000D};
  logic [11:0] ac [3]  = '{OFF_ACS_HDR, OFF_ACS_CAP, OFF_EGRESS};

  pbacs_regs dut (
    .aclk               (aclk),
    .aresetn            (aresetn),
    .port_is_downstream (ds),
    .eeprom_load        (ld),
    .eeprom_base_power  (bp),
    .eeprom_sys_alloc   (sa),
    .s_axil_awaddr      (awaddr),
    .s_axil_awvalid     (awvalid),
    .s_axil_awready     (awready),
    .s_axil_wdata       (wdata),
    .s_axil_wstrb       (wstrb),
    .s_axil_wvalid      (wvalid),
    .s_axil_wready      (wready),
    .s_axil_bresp       (bresp),
    .s_axil_bvalid      (bvalid),
    .s_axil_bready      (bready),
    .s_axil_araddr      (araddr),
    .s_axil_arvalid     (arvalid),
    .s_axil_arready     (arready),
    .s_axil_rdata       (rdata),
    .s_axil_rresp       (rresp),
    .s_axil_rvalid      (rvalid),
    .s_axil_rready      (rready),
    .acs_enable         (acs_en),
    .egress_block       (egr)
  );

  initial begin
    forever #20 aclk = ~aclk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  // budget entry expected for a selection and base power
  function automatic logic [31:0] ent(input logic [7:0] sl, input logic [7:0] b);
    if (sl == 8'h00) return {11'h0, 3'h2, 3'h7, 7'h0, b};
    if (sl == 8'h01) return {11'h0, 3'h2, 3'h1, 7'h0, b};
    return 32'h0;
  endfunction

  task automatic chk(input string n, input logic [31:0] ex, input logic [31:0] got);
    compares++;
    if (got !== ex) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", n, ex, got);
    end
  endtask

  task automatic end_of_test();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic rst(input logic d);
    @(posedge aclk);
    ds      <= d;
    aresetn <= 1'h0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] sb,
                    input logic [1:0] r);
    logic tb;
    bq.push_back(r);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= sb;
    awvalid <= 1'h1;
    wvalid  <= 1'h1;
    bready  <= 1'h1;
    do begin
      @(posedge aclk);
      tb = bvalid && bready;
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
      if (tb) bready <= 1'h0;
    end while (!tb);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    logic tr;
    rq.push_back({r, d});
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'h1;
    rready  <= 1'h1;
    do begin
      @(posedge aclk);
      tr = rvalid && rready;
      if (arvalid && arready) arvalid <= 1'h0;
      if (tr) rready <= 1'h0;
    end while (!tr);
  endtask

  // result watcher against the oldest note
  always @(posedge aclk) begin
    if (rvalid === 1'h1 && rready === 1'h1) begin
      e = (rq.size() > 0) ? rq.pop_front() : 34'h3FFFFFFFF;
      chk("rdata", e[31:0], rdata);
      chk("rresp", 32'(e[33:32]), 32'(rresp));
    end
    if (bvalid === 1'h1 && bready === 1'h1) begin
      chk("bresp", 32'((bq.size() > 0) ? bq.pop_front() : 2'h3), 32'(bresp));
    end
  end

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      failures++;
      end_of_test();
    end
  end

  initial begin
    rst(1'h1);
    rd(OFF_SEL, 32'h0, RESP_OKAY);
    rd(OFF_ACS_CAP, 32'h0000_087F, RESP_OKAY);
    rd(OFF_EGRESS, 32'h0, RESP_OKAY);
    for (i = 0; i < 4; i++) begin
      wr(ro[i], 32'hFFFF_FFFF, 4'hF, RESP_OKAY);
      rd(ro[i], re[i], RESP_OKAY);
    end
    wr(OFF_ACS_CAP, 32'hFFFF_FFFF, 4'hF, RESP_OKAY);
    rd(OFF_ACS_CAP, 32'h007F_087F, RESP_OKAY);
    chk("acs_en", 32'h7F, 32'(acs_en));
    rnd = lfsr(rnd);
    wr(OFF_ACS_CAP, rnd, 4'hF, RESP_OKAY);
    wr(OFF_ACS_CAP, 32'h0, 4'hB, RESP_OKAY);
    rd(OFF_ACS_CAP, {9'h0, rnd[22:16], 16'h087F}, RESP_OKAY);
    chk("acs_en", 32'(rnd[22:16]), 32'(acs_en));
    for (i = 0; i < 3; i++) begin
      rnd = lfsr(rnd);
      wr(OFF_EGRESS, rnd, 4'hF, RESP_OKAY);
      rd(OFF_EGRESS, {24'h0, rnd[7:0]}, RESP_OKAY);
      chk("egress", 32'(rnd[7:0]), 32'(egr));
    end
    for (i = 0; i < 6; i++) begin
      rnd = lfsr(rnd);
      s = (i < 4) ? st[i] : rnd[7:0];
      wr(OFF_SEL, {rnd[31:8], s}, 4'hF, RESP_OKAY);
      rd(OFF_SEL, {24'h0, s}, RESP_OKAY);
      rd(OFF_DATA, ent(s, 8'h04), RESP_OKAY);
    end
    // unmapped places
    rd(12'h000, 32'h0, RESP_SLVERR);
    wr(12'h21C, rnd, 4'hF, RESP_SLVERR);
    // external default load
    rnd = lfsr(rnd);
    @(posedge aclk);
    bp <= rnd[7:0];
    sa <= 1'h1;
    ld <= 1'h1;
    @(posedge aclk);
    ld <= 1'h0;
    wr(OFF_SEL, 32'h1, 4'hF, RESP_OKAY);
    rd(OFF_DATA, ent(8'h01, rnd[7:0]), RESP_OKAY);
    rd(OFF_ALLOC, 32'h1, RESP_OKAY);
    // upstream role after a second reset
    rst(1'h0);
    rd(OFF_PB_HDR, 32'h2301_0004, RESP_OKAY);
    rd(OFF_DATA, ent(8'h00, 8'h04), RESP_OKAY);
    rd(OFF_ALLOC, 32'h0, RESP_OKAY);
    for (i = 0; i < 3; i++) begin
      wr(ac[i], 32'hFFFF_FFFF, 4'hF, RESP_SLVERR);
      rd(ac[i], 32'h0, RESP_SLVERR);
    end
    chk("acs_en", 32'h0, 32'(acs_en));
    chk("egress", 32'h0, 32'(egr));
    @(posedge aclk);
    @(posedge aclk);
    chk("pending", 32'h0, 32'(rq.size() + bq.size()));
    end_of_test();
  end
endmodule
